// >>> rtl/param_store.sv
// Small parameter memory with registered read data
`timescale 1ns/10ps
module param_store
  import scurve_pkg::*;
#(
  parameter int DEPTH = PRM_N
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire prm_wr_t wr_i,
  input wire logic [PRM_AW-1:0] rd_addr_i,
  output logic [DAT_W-1:0] rd_data_o
);

  logic [DAT_W-1:0] mem_q [DEPTH];

  // Write port; cleared at reset so a drive never starts on junk
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (wr_i.en) begin
      mem_q[wr_i.addr] <= wr_i.data;
    end
  end

  // Registered read port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem_q[rd_addr_i];
    end
  end

  AST_RD_AFTER_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i.en ##1 (!wr_i.en && rd_addr_i == $past(wr_i.addr)))
    |=> rd_data_o == $past(wr_i.data, 2))
    else $error("parameter read does not return written word");

endmodule

// >>> rtl/rate_accum.sv
// Fractional rate accumulator that emits one tick per overflow
`timescale 1ns/10ps
module rate_accum #(
  parameter int W = 16,
  parameter int LIMIT = 65536
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic [W-1:0] add_i,
  output logic tick_o
);

  localparam int AW = $clog2(LIMIT) + 1;
  localparam int SW = AW + W;
  localparam logic [SW-1:0] LIM = SW'(LIMIT);

  logic [AW-1:0] acc_q;
  logic [SW-1:0] sum;

  // Add must stay below LIMIT, otherwise ticks are lost
  assign sum = SW'(acc_q) + SW'(add_i);

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      acc_q <= '0;
    end else if (sum >= LIM) begin
      acc_q <= AW'(sum - LIM);
    end else begin
      acc_q <= AW'(sum);
    end
  end

  // Registered tick, one cycle per overflow
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= !clr_i && (sum >= LIM);
    end
  end

  AST_ACC_BELOW_LIMIT: assert property (@(posedge clk_i) disable iff (rst_i)
    SW'(acc_q) < LIM)
    else $error("rate accumulator above its limit");

endmodule

// >>> rtl/s_curve_pulse_profile.sv
// S-curve drive pulse profile generator with a Wishbone register slave
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps

module s_curve_pulse_profile
  import scurve_pkg::*;
#(
  parameter int ACCEL_DIV = ACC_LIMIT,
  parameter int PULSE_DIV = PULSE_LIMIT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic drive_pulse_o,
  output logic drive_dir_o,
  output logic busy_o
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_LOAD, ST_ACC_UP, ST_ACC_HOLD, ST_ACC_DOWN,
    ST_CRUISE, ST_DEC_UP, ST_DEC_HOLD, ST_DEC_DOWN, ST_FLOOR
  } state_t;

  state_t st_q;
  mode_t mode_q, run_mode_q;
  cmd_t cmd;
  prm_wr_t prm_wr;
  logic fixed_q, dir_q, stop_pend_q, ack_q, wait_q, ld_vld_q;
  logic [1:0] kind_q;
  logic [JRK_W-1:0] jerk_acc_q, jerk_dec_q, jerk_sel, jcnt_q;
  logic [ACC_W-1:0] acc_max_q, dec_max_q, dec_lim, a_q;
  logic [SPD_W-1:0] start_q, drive_q, speed_q, gain_q;
  logic [PCNT_W-1:0] pulses_q, dpoint_q, pcnt_q, pacc_q;
  logic [PRM_AW-1:0] ld_idx_q, ld_dst_q, rd_addr;
  logic [DAT_W-1:0] prm_rd, rdata;
  logic req, wr_fire, is_prm, cmd_fire, running, accel_ph, decel_ph;
  logic s_on, sep, jerk_step, spd_tick, pls_tick, fin, dec_go, want_dec;
  logic near_top, near_floor;

  // ****************************************
  // Wishbone slave
  // ****************************************
  assign req = wb_cyc_i && wb_stb_i;
  assign is_prm = wb_adr_i[PRM_SEL_BIT];
  // Writes land at the edge where the master sees ack
  assign wr_fire = req && wb_we_i && ack_q;
  assign cmd = cmd_t'(wb_dat_i[CMD_W-1:0]);
  assign cmd_fire = wr_fire && !is_prm && wb_adr_i == OFS_CMD && wb_sel_i[0];
  assign wb_ack_o = ack_q;

  // One wait cycle covers the memory read latency; parameter loading holds the bus off
  always_ff @(posedge clk_i) begin
    if (rst_i || ack_q) begin
      wait_q <= 1'b0;
    end else if (req && st_q != ST_LOAD) begin
      wait_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && wait_q && !ack_q;
    end
  end

  // Read mux; mode and command are write-only and read as zero
  always_comb begin
    rdata = '0;
    if (is_prm) begin
      rdata = prm_rd;
    end else if (wb_adr_i == OFS_STAT) begin
      rdata[STAT_BUSY] = st_q != ST_IDLE;
      rdata[STAT_ACC] = accel_ph;
      rdata[STAT_DEC] = decel_ph;
      rdata[STAT_SCRV] = s_on && running;
      rdata[STAT_STOP] = stop_pend_q;
      rdata[STAT_A_LSB +: ACC_W] = a_q;
    end else if (wb_adr_i == OFS_SPEED) begin
      rdata[SPD_W-1:0] = speed_q;
    end else if (wb_adr_i == OFS_PCNT) begin
      rdata = pcnt_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (req && wait_q && !ack_q) begin
      wb_dat_o <= rdata;
    end
  end

  // Mode register; bit layout decides symmetric or asymmetric drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= mode_t'(MODE_RST);
    end else if (wr_fire && !is_prm && wb_adr_i == OFS_MODE && wb_sel_i[0]) begin
      mode_q <= mode_t'(wb_dat_i[2:0]);
    end
  end

  // ****************************************
  // Parameter store and load sequence
  // ****************************************
  // Parameter words need all four byte lanes; partial writes are dropped
  assign prm_wr = '{en: wr_fire && is_prm && (&wb_sel_i),
                    addr: wb_adr_i[PRM_IDX_LSB +: PRM_AW], data: wb_dat_i};
  assign rd_addr = (st_q == ST_LOAD) ? ld_idx_q : wb_adr_i[PRM_IDX_LSB +: PRM_AW];

  param_store #(.DEPTH(PRM_N)) u_store (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(prm_wr),
    .rd_addr_i(rd_addr),
    .rd_data_o(prm_rd)
  );

  // Walk all slots once; the working copies stay fixed for the drive
  always_ff @(posedge clk_i) begin
    if (rst_i || st_q != ST_LOAD) begin
      ld_idx_q <= '0;
      ld_vld_q <= 1'b0;
      ld_dst_q <= '0;
    end else begin
      ld_idx_q <= ld_idx_q + PRM_AW'(1);
      ld_vld_q <= 1'b1;
      ld_dst_q <= ld_idx_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      jerk_acc_q <= '0;
      jerk_dec_q <= '0;
      acc_max_q <= '0;
      dec_max_q <= '0;
      start_q <= '0;
      drive_q <= '0;
      pulses_q <= '0;
      dpoint_q <= '0;
    end else if (st_q == ST_LOAD && ld_vld_q) begin
      unique case (ld_dst_q)
        PI_JERK_ACC: jerk_acc_q <= prm_rd[JRK_W-1:0];
        PI_JERK_DEC: jerk_dec_q <= prm_rd[JRK_W-1:0];
        PI_ACC: acc_max_q <= prm_rd[ACC_W-1:0];
        PI_DEC: dec_max_q <= prm_rd[ACC_W-1:0];
        PI_START: start_q <= prm_rd[SPD_W-1:0];
        PI_DRIVE: drive_q <= prm_rd[SPD_W-1:0];
        PI_PULSES: pulses_q <= prm_rd;
        PI_DPOINT: dpoint_q <= prm_rd;
      endcase
    end
  end

  // Drive command capture; fixed wins when both start bits are set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fixed_q <= 1'b0;
      dir_q <= 1'b0;
      kind_q <= KIND_LINEAR;
      run_mode_q <= mode_t'(MODE_RST);
    end else if (st_q == ST_IDLE && cmd_fire && (cmd.fixed || cmd.cont)) begin
      fixed_q <= cmd.fixed;
      dir_q <= cmd.dir;
      kind_q <= cmd.kind;
      run_mode_q <= mode_q;
    end
  end

  // A stop is held until the drive ends; ignored while idle
  always_ff @(posedge clk_i) begin
    if (rst_i || st_q == ST_IDLE) begin
      stop_pend_q <= 1'b0;
    end else if (cmd_fire && cmd.stop) begin
      stop_pend_q <= 1'b1;
    end
  end

  // ****************************************
  // Profile decode
  // ****************************************
  assign running = st_q != ST_IDLE && st_q != ST_LOAD;
  assign accel_ph = st_q inside {ST_ACC_UP, ST_ACC_HOLD, ST_ACC_DOWN};
  assign decel_ph = st_q inside {ST_DEC_UP, ST_DEC_HOLD, ST_DEC_DOWN};
  assign s_on = run_mode_q.scurve && kind_q == KIND_LINEAR;
  assign sep = run_mode_q.sepdec;
  assign jerk_sel = (decel_ph && sep) ? jerk_dec_q : jerk_acc_q;
  assign dec_lim = sep ? dec_max_q : acc_max_q;
  assign jerk_step = running && jcnt_q >= jerk_sel;
  assign fin = fixed_q && pls_tick && running && (pcnt_q + PCNT_W'(1) == pulses_q);
  // Manual point or symmetric mirror of acceleration pulses; never in continuous drive
  assign dec_go = fixed_q && (run_mode_q.manual ? pcnt_q >= dpoint_q :
                  pulses_q - pcnt_q <= pacc_q);
  assign want_dec = dec_go || stop_pend_q;
  // Speed still to gain or lose is compared with what the jerk ramp took
  assign near_top = speed_q >= drive_q || drive_q - speed_q <= gain_q;
  assign near_floor = speed_q <= start_q || speed_q - start_q <= gain_q;
  assign busy_o = st_q != ST_IDLE;

  // ****************************************
  // Profile state machine
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
    end else if (fin) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: if (cmd_fire && (cmd.fixed || cmd.cont)) begin
          st_q <= ST_LOAD;
        end
        ST_LOAD: if (ld_vld_q && ld_dst_q == PI_DPOINT) begin
          if (fixed_q && pulses_q == '0) begin
            st_q <= ST_IDLE;
          end else begin
            st_q <= s_on ? ST_ACC_UP : ST_ACC_HOLD;
          end
        end
        ST_ACC_UP: if (want_dec || near_top) begin
          st_q <= ST_ACC_DOWN;
        end else if (a_q >= acc_max_q) begin
          st_q <= ST_ACC_HOLD;
        end
        ST_ACC_HOLD: if (!s_on) begin
          if (want_dec) begin
            st_q <= ST_DEC_HOLD;
          end else if (speed_q >= drive_q) begin
            st_q <= ST_CRUISE;
          end
        end else if (want_dec || near_top) begin
          st_q <= ST_ACC_DOWN;
        end
        ST_ACC_DOWN: if (a_q == '0) begin
          st_q <= want_dec ? ST_DEC_UP : ST_CRUISE;
        end
        ST_CRUISE: if (want_dec) begin
          st_q <= s_on ? ST_DEC_UP : ST_DEC_HOLD;
        end
        ST_DEC_UP: if (near_floor) begin
          st_q <= ST_DEC_DOWN;
        end else if (a_q >= dec_lim) begin
          st_q <= ST_DEC_HOLD;
        end
        ST_DEC_HOLD: if (!s_on) begin
          if (speed_q <= start_q) begin
            st_q <= ST_FLOOR;
          end
        end else if (near_floor) begin
          st_q <= ST_DEC_DOWN;
        end
        ST_DEC_DOWN: if (a_q == '0) begin
          st_q <= ST_FLOOR;
        end
        // Fixed drive runs out its remaining pulses at start speed
        ST_FLOOR: if (!fixed_q) begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Jerk divider: one acceleration step every code plus one cycles
  always_ff @(posedge clk_i) begin
    if (rst_i || !running || jerk_step) begin
      jcnt_q <= '0;
    end else begin
      jcnt_q <= jcnt_q + JRK_W'(1);
    end
  end

  // Acceleration value; linear holds jump straight to the limit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_q <= '0;
    end else begin
      unique case (st_q)
        ST_ACC_UP: if (jerk_step && a_q < acc_max_q) begin
          a_q <= a_q + ACC_W'(1);
        end
        ST_DEC_UP: if (jerk_step && a_q < dec_lim) begin
          a_q <= a_q + ACC_W'(1);
        end
        ST_ACC_DOWN, ST_DEC_DOWN: if (jerk_step && a_q != '0) begin
          a_q <= a_q - ACC_W'(1);
        end
        ST_ACC_HOLD: if (!s_on) begin
          a_q <= acc_max_q;
        end
        ST_DEC_HOLD: if (!s_on) begin
          a_q <= dec_lim;
        end
        ST_IDLE, ST_LOAD, ST_CRUISE, ST_FLOOR: a_q <= '0;
      endcase
    end
  end

  rate_accum #(.W(ACC_W), .LIMIT(ACCEL_DIV)) u_speed_acc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(!running),
    .add_i(a_q),
    .tick_o(spd_tick)
  );

  // Speed moves one unit per accumulator overflow, clamped to start and drive
  always_ff @(posedge clk_i) begin
    if (rst_i || st_q == ST_IDLE) begin
      speed_q <= '0;
    end else if (st_q == ST_LOAD || st_q == ST_FLOOR) begin
      speed_q <= start_q;
    end else if (st_q == ST_CRUISE) begin
      speed_q <= drive_q;
    end else if (spd_tick && accel_ph && speed_q < drive_q) begin
      speed_q <= speed_q + SPD_W'(1);
    end else if (spd_tick && decel_ph && speed_q > start_q) begin
      speed_q <= speed_q - SPD_W'(1);
    end
  end

  // Speed gained in the jerk-up phase sizes the matching ramp-down
  always_ff @(posedge clk_i) begin
    if (rst_i || !running || st_q == ST_CRUISE || (st_q == ST_ACC_DOWN && a_q == '0)) begin
      gain_q <= '0;
    end else if (spd_tick && (st_q == ST_ACC_UP || st_q == ST_DEC_UP)) begin
      gain_q <= gain_q + SPD_W'(1);
    end
  end

  rate_accum #(.W(SPD_W), .LIMIT(PULSE_DIV)) u_pulse_acc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(!running),
    .add_i(speed_q),
    .tick_o(pls_tick)
  );

  // Output and acceleration pulse counters
  always_ff @(posedge clk_i) begin
    if (rst_i || st_q == ST_LOAD) begin
      pcnt_q <= '0;
      pacc_q <= '0;
    end else if (pls_tick && running) begin
      pcnt_q <= pcnt_q + PCNT_W'(1);
      pacc_q <= accel_ph ? pacc_q + PCNT_W'(1) : pacc_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_pulse_o <= 1'b0;
      drive_dir_o <= 1'b0;
    end else begin
      drive_pulse_o <= pls_tick && running;
      drive_dir_o <= dir_q;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ramp_end;
    st_q == ST_ACC_DOWN && stop_pend_q && !fin ##1 st_q == ST_DEC_UP;
  endsequence
  sequence s_bus_req;
    req && !wait_q && !ack_q && st_q != ST_LOAD ##1 req;
  endsequence

  AST_STOP_RAMPS_DOWN: assert property (
    (st_q == ST_ACC_UP && stop_pend_q && !fin) |=> st_q == ST_ACC_DOWN)
    else $error("stop during jerk-up did not ramp acceleration down");
  AST_DEC_FROM_ZERO: assert property (s_ramp_end |-> a_q == '0)
    else $error("deceleration began with acceleration not zero");
  AST_NO_SCURVE_INTERP: assert property (
    st_q inside {ST_ACC_UP, ST_ACC_DOWN, ST_DEC_UP, ST_DEC_DOWN}
    |-> run_mode_q.scurve && kind_q == KIND_LINEAR)
    else $error("S-curve phase entered for interpolation drive");
  AST_FIXED_COUNT_END: assert property (
    (running && fixed_q && pls_tick && pcnt_q + PCNT_W'(1) == pulses_q)
    |=> st_q == ST_IDLE ##1 !drive_pulse_o)
    else $error("fixed drive did not end at its pulse count");
  AST_FLOOR_AT_START: assert property (
    (st_q == ST_FLOOR && $past(st_q) == ST_FLOOR) |-> speed_q == start_q)
    else $error("floor phase not at start speed");
  AST_DEC_JERK: assert property (
    (st_q == ST_DEC_UP && $past(st_q) == ST_DEC_UP && sep && a_q != $past(a_q))
    |-> $past(jcnt_q) >= $past(jerk_dec_q))
    else $error("deceleration step taken before deceleration jerk count");
  AST_MANUAL_POINT: assert property (
    (st_q == ST_CRUISE && fixed_q && run_mode_q.manual && pcnt_q >= dpoint_q)
    |=> st_q inside {ST_DEC_UP, ST_DEC_HOLD, ST_IDLE})
    else $error("manual deceleration point passed without decelerating");
  AST_CONT_NO_COUNT: assert property (
    (st_q == ST_CRUISE && !fixed_q && !stop_pend_q && !cmd_fire) |=> st_q == ST_CRUISE)
    else $error("continuous drive left cruise without a stop");
  AST_LOAD_START: assert property (
    (st_q == ST_LOAD && ld_vld_q && ld_dst_q == PI_DPOINT && pulses_q != '0)
    |=> running && speed_q == start_q)
    else $error("drive did not begin at start speed after load");
  AST_BUS_ACK: assert property (s_bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not two cycles after request");

endmodule

// >>> rtl/scurve_pkg.sv
// Shared constants and types for the S-curve pulse profile block
package scurve_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADR_W = 6;
  localparam int DAT_W = 32;
  localparam int SPD_W = 16;
  localparam int ACC_W = 14;
  localparam int JRK_W = 16;
  localparam int PCNT_W = 32;
  localparam int PRM_AW = 3;
  localparam int PRM_N = 8;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [ADR_W-1:0] OFS_MODE = 6'h00;
  localparam logic [ADR_W-1:0] OFS_CMD = 6'h04;
  localparam logic [ADR_W-1:0] OFS_STAT = 6'h08;
  localparam logic [ADR_W-1:0] OFS_SPEED = 6'h0C;
  localparam logic [ADR_W-1:0] OFS_PCNT = 6'h10;
  // Address bit that selects the parameter block at 20h..3Ch
  localparam int PRM_SEL_BIT = 5;
  localparam int PRM_IDX_LSB = 2;

  // Parameter slots in the parameter block
  localparam logic [PRM_AW-1:0] PI_JERK_ACC = 3'h0;
  localparam logic [PRM_AW-1:0] PI_JERK_DEC = 3'h1;
  localparam logic [PRM_AW-1:0] PI_ACC = 3'h2;
  localparam logic [PRM_AW-1:0] PI_DEC = 3'h3;
  localparam logic [PRM_AW-1:0] PI_START = 3'h4;
  localparam logic [PRM_AW-1:0] PI_DRIVE = 3'h5;
  localparam logic [PRM_AW-1:0] PI_PULSES = 3'h6;
  localparam logic [PRM_AW-1:0] PI_DPOINT = 3'h7;

  // ****************************************
  // Mode, command and status fields
  // ****************************************
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [2:0] MODE_ASYM = 3'h7;
  localparam int CMD_W = 6;
  localparam logic [1:0] KIND_LINEAR = 2'h0;
  localparam logic [1:0] KIND_CIRC = 2'h1;
  localparam logic [1:0] KIND_BITPAT = 2'h2;
  localparam logic [1:0] KIND_CONTIN = 2'h3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ACC = 1;
  localparam int STAT_DEC = 2;
  localparam int STAT_SCRV = 3;
  localparam int STAT_STOP = 4;
  localparam int STAT_A_LSB = 16;

  // Rate scaling; jerk rate is JERK_CONST / code x magnification
  localparam int ACC_LIMIT = 16384;
  localparam int PULSE_LIMIT = 65536;
  localparam int JERK_CONST = 62_500_000;

  // Mode bits: bit 2 S-curve, bit 1 separate decel, bit 0 manual
  typedef struct packed {
    logic scurve;
    logic sepdec;
    logic manual;
  } mode_t;

  // Command word: bits 5:4 drive kind, 3 dir, 2 stop, 1 cont, 0 fixed
  typedef struct packed {
    logic [1:0] kind;
    logic dir;
    logic stop;
    logic cont;
    logic fixed;
  } cmd_t;

  typedef struct packed {
    logic en;
    logic [PRM_AW-1:0] addr;
    logic [DAT_W-1:0] data;
  } prm_wr_t;

endpackage

// >>> sim/motor_driver_model.sv
// Motor driver stand-in that counts the drive pulses it receives
`timescale 1ns/10ps
module motor_driver_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic pulse_i,
  input wire logic dir_i,
  output logic [31:0] count_o,
  output logic [31:0] up_o
);
  // Every one-cycle pulse is one step; steps with direction high are also counted apart
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      count_o <= 32'h0;
      up_o <= 32'h0;
    end else if (pulse_i) begin
      count_o <= count_o + 32'h1;
      up_o <= up_o + {31'h0, dir_i};
    end
  end
endmodule

// >>> sim/s_curve_pulse_profile_bench.sv
// Self-checking bench for the S-curve pulse profile generator
`timescale 1ns/10ps
module s_curve_pulse_profile_bench;
  import scurve_pkg::*;
  // ****************************************
  // Wiring, clock and helpers
  // ****************************************
  typedef struct packed {logic [1:0] kind; logic [2:0] mode; logic scrv;} row_t;
  row_t rows [6] = '{'{KIND_LINEAR, 3'h4, 1'b1}, '{KIND_CIRC, 3'h4, 1'b0},
    '{KIND_BITPAT, 3'h4, 1'b0}, '{KIND_CONTIN, 3'h4, 1'b0},
    '{KIND_LINEAR, MODE_ASYM, 1'b1}, '{KIND_LINEAR, 3'h0, 1'b0}};
  logic clk_i, rst_i, cyc, stb, we, ack, pulse, dir, busy, clr;
  logic [3:0] sel;
  logic [ADR_W-1:0] adr;
  logic [DAT_W-1:0] wdat, rdat, q;
  logic [31:0] cnt, ups;
  logic [ACC_W-1:0] ramp;
  int n_errors = 0;
  int total_checks = 0;

  // Free-running 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  s_curve_pulse_profile i_s_curve_pulse_profile (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .drive_pulse_o(pulse),
    .drive_dir_o(dir), .busy_o(busy));
  motor_driver_model i_motor_driver_model (.clk_i(clk_i), .rst_i(rst_i), .clr_i(clr),
    .pulse_i(pulse), .dir_i(dir), .count_o(cnt), .up_o(ups));

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled, then release
  task wb(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d,
          input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 40);
    chk("ack", 32'h1, {31'h0, ack});
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask

  task rd(input logic [ADR_W-1:0] a);
    wb(1'b0, a, 32'h0, 4'hF);
  endtask

  function automatic logic [ADR_W-1:0] pa(input int i);
    return ADR_W'(32 + 4 * i);
  endfunction

  // Small jerk codes keep runs short; acceleration limits sit at 1F40h, well below the 14-bit maximum
  task setup(input logic [2:0] m, input logic [31:0] p, input logic [31:0] dp);
    logic [31:0] prm [8];
    prm = '{32'h2, 32'h5, 32'h1F40, 32'h1F40, 32'h7D0, 32'h1F40, p, dp};
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    wr(OFS_MODE, {29'h0, m});
    for (int i = 0; i < 8; i++) wr(pa(i), prm[i]);
  endtask

  task wait_busy(input logic v);
    int k;
    k = 0;
    while (busy !== v && k < 40000) begin
      @(posedge clk_i);
      k++;
    end
    chk("busy", {31'h0, v}, {31'h0, busy});
    // The last pulse reaches the driver model one edge after busy drops
    repeat (2) @(posedge clk_i);
  endtask

  task wait_cnt(input logic [31:0] n);
    int k;
    k = 0;
    while (cnt < n && k < 20000) begin
      @(posedge clk_i);
      k++;
    end
    chk("count reached", 32'h1, {31'h0, cnt >= n});
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog; the drives above take about 3700 cycles, so this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    $display("watchdog expired");
    end_of_test;
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, clr} = 4'h0;
    sel = 4'h0;
    adr = 6'h00;
    wdat = 32'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_STAT);
    chk("status reset", 32'h0, q);
    rd(pa(7));
    chk("point reset", 32'h0, q);
    wb(1'b1, pa(7), 32'h1234_5678, 4'h3);
    rd(pa(7));
    chk("partial write", 32'h0, q);
    wr(pa(7), 32'h0000_1234);
    rd(pa(7));
    chk("point readback", 32'h0000_1234, q);
    rd(6'h14);
    chk("unmapped", 32'h0, q);
    $display("test registers done");
    // Every drive kind, and linear under several modes; load time of 9 cycles is fixed
    for (int i = 0; i < 6; i++) begin
      setup(rows[i].mode, 32'h4, 32'h2);
      wr(OFS_CMD, {26'h0, rows[i].kind, i[0], 3'h1});
      repeat (15) @(posedge clk_i);
      rd(OFS_STAT);
      chk("scurve flag", {31'h0, rows[i].scrv}, {31'h0, q[STAT_SCRV]});
      wait_busy(1'b0);
      chk("pulses", 32'h4, cnt);
      chk("dir pulses", i[0] ? 32'h4 : 32'h0, ups);
    end
    $display("test drive kinds done");
    // Asymmetric drive turns to deceleration only at the manual point
    setup(MODE_ASYM, 32'h28, 32'h14);
    wr(OFS_CMD, 32'h1);
    wait_cnt(32'hA);
    rd(OFS_STAT);
    chk("decel early", 32'h0, {31'h0, q[STAT_DEC]});
    // Point falls in the jerk-up phase, so acceleration must now be ramping down
    wait_cnt(32'h18);
    rd(OFS_STAT);
    ramp = q[STAT_A_LSB +: ACC_W];
    repeat (30) @(posedge clk_i);
    rd(OFS_STAT);
    chk("ramp down at point", 32'h1, {31'h0, q[STAT_A_LSB +: ACC_W] < ramp});
    wait_busy(1'b0);
    chk("asym pulses", 32'h28, cnt);
    $display("test manual point done");
    // Continuous drive runs past a zero count, then a stop mid-acceleration
    setup(3'h4, 32'h0, 32'h0);
    wr(OFS_CMD, 32'h2);
    wait_cnt(32'h8);
    chk("cont busy", 32'h1, {31'h0, busy});
    wr(OFS_CMD, 32'h4);
    rd(OFS_STAT);
    chk("no decel yet", 32'h0, {31'h0, q[STAT_DEC]});
    chk("stop pending", 32'h1, {31'h0, q[STAT_STOP]});
    wait_busy(1'b0);
    $display("test stop done");
    // Reset in mid-drive silences the pins and clears the parameter store
    setup(3'h4, 32'h0, 32'h0);
    wr(OFS_CMD, 32'hA);
    wait_cnt(32'h2);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("reset busy", 32'h0, {31'h0, busy});
    chk("reset pulse", 32'h0, {31'h0, pulse});
    chk("reset dir", 32'h0, {31'h0, dir});
    rst_i <= 1'b0;
    rd(pa(0));
    chk("reset store", 32'h0, q);
    $display("test mid reset done");
    end_of_test;
  end
endmodule
